// ==== hdl/adc_ctl_map.svh ====
`ifndef ADC_CTL_MAP_SVH
`define ADC_CTL_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define REG_CONFIG 8'h00
`define REG_POWER 8'h08
`define REG_DIVIDE 8'h0c
`define REG_STATUS 8'h10
`define REG_OUTPUT 8'h14
`define REG_IRQ_STATUS 8'h18
`define REG_IRQ_MASK 8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_FMT_LSB 0
`define CFG_FMT_MSB 1
`define CFG_STAB 2
`define CFG_CLK_INV 3
`define PWR_DOWN 0
`define PWR_STANDBY 1
`define OUT_DIS_A 0
`define OUT_DIS_B 1
`define DIV_MSB 2
`define ST_LOCKED 0
`define ST_BYPASS 1
`define ST_PD 2
`define ST_SERIAL 3
`define ST_REF_ON 4
`define IRQ_OVER_A 0
`define IRQ_OVER_B 1
`define IRQ_LOCK 2
`define IRQ_UNLOCK 3
`define IRQ_W 4

// ****************************************************************
// Reset values
// ****************************************************************
`define CONFIG_RST 8'h04
`define POWER_RST 8'h00
`define DIVIDE_RST 8'h00
`define OUTPUT_RST 8'h00
`define IRQ_MASK_RST 4'h0

// ****************************************************************
// Codes, pins and timing
// ****************************************************************
`define CODE_W 14
`define FS_POS 16'sh1fff
`define FS_NEG 16'she000
`define TC_POS 14'h1fff
`define TC_NEG 14'h2000
`define MSB_FLIP 14'h2000
`define PIPE_LAT 12
`define CLK_MHZ 125
`define CLK_PERIOD_NS 8
`define STAB_MIN_MHZ 20
`define LOCK_TIME_NS 2000
`define PIN_PD 0
`define PIN_DIS 1
`define PIN_FMT 2
`define PIN_STAB 3
`define PIN_SERIAL 4
`define PIN_DUTY 5
`define PIN_W 6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hdl/adc_ctl_pkg.sv ====
`include "adc_ctl_map.svh"

package adc_ctl_pkg;

  typedef enum logic [1:0] {
    CODE_OFFSET = 2'h0,
    CODE_TWOS = 2'h1,
    CODE_GRAY = 2'h2
  } coding_t;

  // Gray codes along off -> wait -> locked
  typedef enum logic [1:0] {
    LK_OFF = 2'h0,
    LK_WAIT = 2'h1,
    LK_LOCKED = 2'h3
  } lock_state_t;

  typedef struct packed {
    logic over;
    logic [`CODE_W-1:0] code;
  } word_t;

endpackage

// ==== hdl/sample_pipe_if.sv ====
interface sample_pipe_if;
  logic shift;
  adc_ctl_pkg::word_t in_a;
  adc_ctl_pkg::word_t in_b;
  adc_ctl_pkg::word_t out_a;
  adc_ctl_pkg::word_t out_b;

  modport pipe (input shift, input in_a, input in_b, output out_a, output out_b);
  modport feed (output shift, output in_a, output in_b, input out_a, input out_b);
endinterface

// ==== hdl/sample_pipe.sv ====
`include "adc_ctl_map.svh"

module sample_pipe #(
  parameter int LAT = `PIPE_LAT
) (
  input wire logic clk,
  input wire logic rst,
  sample_pipe_if.pipe p
);
  adc_ctl_pkg::word_t mem_a_q [LAT];
  adc_ctl_pkg::word_t mem_b_q [LAT];

  // ****************************************************************
  // Shift one stage per sample edge; output holds between edges
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < LAT; i++)
      begin
        mem_a_q[i] <= '0;
        mem_b_q[i] <= '0;
      end
    end
    else if (p.shift)
    begin
      mem_a_q[0] <= p.in_a;
      mem_b_q[0] <= p.in_b;
      for (int i = 1; i < LAT; i++)
      begin
        mem_a_q[i] <= mem_a_q[i-1];
        mem_b_q[i] <= mem_b_q[i-1];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      p.out_a <= '0;
      p.out_b <= '0;
    end
    else if (p.shift)
    begin
      p.out_a <= mem_a_q[LAT-1];
      p.out_b <= mem_b_q[LAT-1];
    end
  end

endmodule // sample_pipe

// ==== hdl/adc_output_control.sv ====
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`include "adc_ctl_map.svh"

module adc_output_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] sample_a,
  input wire logic [15:0] sample_b,
  input wire logic power_down_ctl_pin,
  input wire logic monitor_out_or_output_disable_pin,
  input wire logic serial_clock_or_format_select_pin,
  input wire logic serial_io_or_stabilizer_select_pin,
  input wire logic serial_mode_pin,
  input wire logic raw_clk_duty,
  output logic [`CODE_W-1:0] data_a,
  output logic [`CODE_W-1:0] data_b,
  output logic overrange_flag_a,
  output logic overrange_flag_b,
  output logic data_oe_a,
  output logic data_oe_b,
  output logic data_clock_out_a,
  output logic data_clock_out_b,
  output logic data_clock_out_oe,
  output logic internal_clk,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int LOCK_CYC = (`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int LAT = `PIPE_LAT;
  localparam int LAT_CHK = `PIPE_LAT + 1;

  function automatic adc_ctl_pkg::word_t encode(input logic [15:0] s, input adc_ctl_pkg::coding_t f);
    adc_ctl_pkg::word_t w;
    logic [`CODE_W-1:0] ob;
    w.over = 1'b0;
    w.code = s[`CODE_W-1:0];
    if ($signed(s) > `FS_POS)
    begin
      w.over = 1'b1;
      w.code = `TC_POS;
    end
    else if ($signed(s) < `FS_NEG)
    begin
      w.over = 1'b1;
      w.code = `TC_NEG;
    end
    ob = w.code ^ `MSB_FLIP;
    case (f)
      adc_ctl_pkg::CODE_TWOS: w.code = w.code;
      adc_ctl_pkg::CODE_GRAY: w.code = ob ^ (ob >> 1);
      default: w.code = ob;
    endcase
    return w;
  endfunction

  // Loop cannot track below the minimum rate
  function automatic logic too_slow(input logic [2:0] div);
    return `CLK_MHZ < `STAB_MIN_MHZ * (int'(div) + 1);
  endfunction

  // ****************************************************************
  // Pin synchronisers and mode strap
  // ****************************************************************
  logic [`PIN_W-1:0] pin_s1_q, pin_s2_q;
  logic rst_d_q, serial_q;

  always_ff @(posedge clk)
  begin
    pin_s1_q <= {raw_clk_duty, serial_mode_pin, serial_io_or_stabilizer_select_pin,
                 serial_clock_or_format_select_pin, monitor_out_or_output_disable_pin, power_down_ctl_pin};
    pin_s2_q <= pin_s1_q;
  end

  // Strap is caught on the first cycle after reset release
  always_ff @(posedge clk)
  begin
    rst_d_q <= rst;
    if (rst_d_q && !rst)
      serial_q <= pin_s2_q[`PIN_SERIAL];
  end

  // ****************************************************************
  // Register file and AXI4-Lite slave
  // ****************************************************************
  logic [7:0] config_q, power_q, divide_q, output_q;
  logic [`IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] status_word;
  logic do_write, rd_take, wr_map, rd_map, rd_clear_irq;
  logic [31:0] rd_word;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign wr_map = aw_addr_q == `REG_CONFIG || aw_addr_q == `REG_POWER || aw_addr_q == `REG_DIVIDE
                  || aw_addr_q == `REG_OUTPUT || aw_addr_q == `REG_IRQ_MASK;
  assign rd_clear_irq = rd_take && s_axi_araddr == `REG_IRQ_STATUS;

  always_comb
  begin
    rd_map = 1'b1;
    rd_word = '0;
    case (s_axi_araddr)
      `REG_CONFIG: rd_word[7:0] = config_q;
      `REG_POWER: rd_word[7:0] = power_q;
      `REG_DIVIDE: rd_word[7:0] = divide_q;
      `REG_STATUS: rd_word = status_word;
      `REG_OUTPUT: rd_word[7:0] = output_q;
      `REG_IRQ_STATUS: rd_word[`IRQ_W-1:0] = irq_stat_q;
      `REG_IRQ_MASK: rd_word[`IRQ_W-1:0] = irq_mask_q;
      default: rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // All fields live in byte lane 0
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      config_q <= `CONFIG_RST;
      power_q <= `POWER_RST;
      divide_q <= `DIVIDE_RST;
      output_q <= `OUTPUT_RST;
      irq_mask_q <= `IRQ_MASK_RST;
    end
    else if (do_write && w_strb_q[0])
    begin
      case (aw_addr_q)
        `REG_CONFIG: config_q <= w_data_q[7:0];
        `REG_POWER: power_q <= w_data_q[7:0];
        `REG_DIVIDE: divide_q <= {5'h00, w_data_q[`DIV_MSB:0]};
        `REG_OUTPUT: output_q <= w_data_q[7:0];
        `REG_IRQ_MASK: irq_mask_q <= w_data_q[`IRQ_W-1:0];
        default: config_q <= config_q;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************************************
  // Mode selection, power and clock divider
  // ****************************************************************
  adc_ctl_pkg::coding_t fmt_eff;
  logic stab_sel, stab_eff, pd_active, standby, sample_en;
  logic [2:0] div_cnt_q;

  always_comb
  begin
    if (serial_q)
      fmt_eff = adc_ctl_pkg::coding_t'(config_q[`CFG_FMT_MSB:`CFG_FMT_LSB]);
    else
      fmt_eff = pin_s2_q[`PIN_FMT] ? adc_ctl_pkg::CODE_TWOS : adc_ctl_pkg::CODE_OFFSET;
  end

  assign stab_sel = serial_q ? config_q[`CFG_STAB] : pin_s2_q[`PIN_STAB];
  assign stab_eff = stab_sel || divide_q[`DIV_MSB:0] != 3'h0;
  assign pd_active = pin_s2_q[`PIN_PD] || (serial_q && power_q[`PWR_DOWN]);
  // Standby stops the sample clock but leaves the reference up
  assign standby = serial_q && power_q[`PWR_STANDBY];
  assign sample_en = div_cnt_q == 3'h0 && !pd_active && !standby;

  always_ff @(posedge clk)
  begin
    if (rst || div_cnt_q >= divide_q[`DIV_MSB:0])
      div_cnt_q <= 3'h0;
    else
      div_cnt_q <= div_cnt_q + 3'h1;
  end

  // ****************************************************************
  // Duty-cycle stabilizer lock model
  // ****************************************************************
  adc_ctl_pkg::lock_state_t lk_q;
  logic [$clog2(LOCK_CYC+1)-1:0] lk_cnt_q;
  logic [2:0] div_seen_q;
  logic locked, rate_change;

  assign locked = lk_q == adc_ctl_pkg::LK_LOCKED;
  assign rate_change = div_seen_q != divide_q[`DIV_MSB:0];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lk_q <= adc_ctl_pkg::LK_OFF;
      lk_cnt_q <= '0;
      div_seen_q <= '0;
    end
    else
    begin
      div_seen_q <= divide_q[`DIV_MSB:0];
      if (!stab_eff || pd_active || too_slow(divide_q[`DIV_MSB:0]))
        lk_q <= adc_ctl_pkg::LK_OFF;
      else
        case (lk_q)
          adc_ctl_pkg::LK_OFF:
          begin
            lk_q <= adc_ctl_pkg::LK_WAIT;
            lk_cnt_q <= '0;
          end
          adc_ctl_pkg::LK_WAIT:
          begin
            // Relock time sits inside the window the controller waits out
            if (rate_change)
              lk_cnt_q <= '0;
            else if (int'(lk_cnt_q) == LOCK_CYC - 1)
              lk_q <= adc_ctl_pkg::LK_LOCKED;
            else
              lk_cnt_q <= lk_cnt_q + 1'b1;
          end
          adc_ctl_pkg::LK_LOCKED:
          begin
            if (rate_change)
            begin
              lk_q <= adc_ctl_pkg::LK_WAIT;
              lk_cnt_q <= '0;
            end
          end
          default: lk_q <= adc_ctl_pkg::LK_OFF;
        endcase
    end
  end

  // Locked: high for the first half of each sample period, rounded up to whole cycles; else raw duty
  always_ff @(posedge clk)
  begin
    if (rst)
      internal_clk <= 1'b0;
    else if (locked)
      internal_clk <= {1'b0, div_cnt_q} <= {1'b0, divide_q[`DIV_MSB:0]} >> 1;
    else
      internal_clk <= pin_s2_q[`PIN_DUTY];
  end

  // ****************************************************************
  // Sample pipeline and outputs
  // ****************************************************************
  sample_pipe_if pif ();
  adc_ctl_pkg::word_t feed_a, feed_b;
  logic sample_en_d_q;

  assign feed_a = encode(sample_a, fmt_eff);
  assign feed_b = encode(sample_b, fmt_eff);
  assign pif.shift = sample_en;
  assign pif.in_a = feed_a;
  assign pif.in_b = feed_b;
  assign {overrange_flag_a, data_a} = pif.out_a;
  assign {overrange_flag_b, data_b} = pif.out_b;

  sample_pipe #(.LAT(LAT)) u_pipe (.clk(clk), .rst(rst), .p(pif));

  // Enables change slowly; not meant for bus sharing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_oe_a <= 1'b0;
      data_oe_b <= 1'b0;
      data_clock_out_oe <= 1'b0;
    end
    else
    begin
      data_oe_a <= !pd_active && !pin_s2_q[`PIN_DIS] && !(serial_q && output_q[`OUT_DIS_A]);
      data_oe_b <= !pd_active && !pin_s2_q[`PIN_DIS] && !(serial_q && output_q[`OUT_DIS_B]);
      data_clock_out_oe <= !pd_active;
    end
  end

  // Edge one cycle after the data update, rising unless CFG_CLK_INV inverts it; at ratio one it stays at that level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sample_en_d_q <= 1'b0;
      data_clock_out_a <= 1'b0;
      data_clock_out_b <= 1'b0;
    end
    else
    begin
      sample_en_d_q <= sample_en;
      data_clock_out_a <= sample_en_d_q ^ config_q[`CFG_CLK_INV];
      data_clock_out_b <= sample_en_d_q ^ config_q[`CFG_CLK_INV];
    end
  end

  // ****************************************************************
  // Status and interrupts
  // ****************************************************************
  logic locked_d_q;

  assign status_word = {27'h0, !pd_active, serial_q, pd_active, !locked, locked};
  assign irq_set = {locked_d_q && !locked, !locked_d_q && locked,
                    sample_en_d_q && overrange_flag_b, sample_en_d_q && overrange_flag_a};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      locked_d_q <= 1'b0;
      irq_stat_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      locked_d_q <= locked;
      irq_stat_q <= (irq_stat_q & ~{`IRQ_W{rd_clear_irq}}) | irq_set;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [4:0] run_q;
  always_ff @(posedge clk)
  begin
    if (rst || !sample_en)
      run_q <= '0;
    else if (run_q != 5'h1f)
      run_q <= run_q + 5'h01;
  end

  a_pipe_latency_a: assert property (int'(run_q) > LAT_CHK |-> pif.out_a == $past(feed_a, LAT_CHK))
    else $error("sample latency wrong on channel a");
  a_pd_drivers_off: assert property (pd_active ##1 pd_active |-> !data_oe_a && !data_oe_b && !data_clock_out_oe)
    else $error("drivers active during power-down");
  a_pd_pin_low: assert property (!pin_s2_q[`PIN_PD] && !power_q[`PWR_DOWN] |-> !pd_active)
    else $error("power-down without cause");
  a_dis_pin_off: assert property (pin_s2_q[`PIN_DIS] |=> !data_oe_a && !data_oe_b)
    else $error("output-disable pin ignored");
  a_chan_dis_b: assert property (serial_q && output_q[`OUT_DIS_B] |=> !data_oe_b)
    else $error("channel b disable ignored");
  a_over_saturate: assert property (feed_a.over |->
    feed_a.code inside {`TC_POS, `TC_NEG, 14'h3fff, 14'h0000, 14'h2000})
    else $error("overrange code not saturated");
  a_mid_scale: assert property (sample_a == 16'h0000 && fmt_eff == adc_ctl_pkg::CODE_OFFSET |-> feed_a.code == `MSB_FLIP)
    else $error("midscale code wrong");
  a_div_forces_stab: assert property (divide_q[`DIV_MSB:0] != 3'h0 |-> stab_eff)
    else $error("divider did not force stabilizer");
  a_slow_no_lock: assert property (too_slow(divide_q[`DIV_MSB:0]) |=> !locked)
    else $error("locked below minimum rate");
  a_bypass_raw: assert property (!locked && !$past(locked) |=> internal_clk == $past(pin_s2_q[`PIN_DUTY]))
    else $error("unlocked clock not bypassed");
  a_clk_out_rises: assert property (sample_en && !config_q[`CFG_CLK_INV] ##1 !config_q[`CFG_CLK_INV]
    |=> data_clock_out_a)
    else $error("data clock did not rise after update");
  a_pin_format: assert property (!serial_q && pin_s2_q[`PIN_FMT] |-> fmt_eff == adc_ctl_pkg::CODE_TWOS)
    else $error("format pin ignored");

  c_lock_gained: cover property (irq_set[`IRQ_LOCK]);
  c_overrange: cover property (sample_en && feed_b.over);
  c_gray_mode: cover property (sample_en && fmt_eff == adc_ctl_pkg::CODE_GRAY);
  c_pd_cycle: cover property (pd_active ##[1:20] !pd_active);

endmodule // adc_output_control

// ==== bench/capture_model.sv ====
module capture_model (
  input wire logic strobe,
  input wire logic oe,
  input wire logic [13:0] data,
  input wire logic flag,
  output logic [14:0] word,
  output int cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cnt = 0;
  // Takes words only on the rising data clock; a released bus is never sampled
  always @(posedge strobe)
  begin
    if (oe === 1'b1)
    begin
      word <= {flag, data};
      cnt <= cnt + 1;
    end
  end
endmodule // capture_model

// ==== bench/adc_output_control_test.sv ====
`include "adc_ctl_map.svh"

module adc_output_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] sample_a = '0;
  logic [15:0] sample_b = '0;
  logic power_down_ctl_pin = 1'b0;
  logic monitor_out_or_output_disable_pin = 1'b0;
  logic serial_clock_or_format_select_pin = 1'b0;
  logic serial_io_or_stabilizer_select_pin = 1'b1;
  logic serial_mode_pin = 1'b1;
  logic raw_clk_duty = 1'b0;
  logic [13:0] data_a, data_b;
  logic overrange_flag_a, overrange_flag_b, data_oe_a, data_oe_b, irq, internal_clk;
  logic data_clock_out_a, data_clock_out_b, data_clock_out_oe;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, seed = 32'hcfdb, r, d;
  logic [14:0] cap_w;
  logic [15:0] v;
  logic [15:0] cn [5] = '{16'he000, 16'h0000, 16'h1fff, 16'h2000, 16'hdfff};
  int cap_n, hi;
  int error_cnt = 0;
  int checks_done = 0;

  adc_output_control dut_u (.clk, .rst, .sample_a, .sample_b, .power_down_ctl_pin,
    .monitor_out_or_output_disable_pin, .serial_clock_or_format_select_pin,
    .serial_io_or_stabilizer_select_pin, .serial_mode_pin, .raw_clk_duty, .data_a, .data_b,
    .overrange_flag_a, .overrange_flag_b, .data_oe_a, .data_oe_b, .data_clock_out_a,
    .data_clock_out_b, .data_clock_out_oe, .internal_clk, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  capture_model cap_u (.strobe(data_clock_out_a), .oe(data_oe_a), .data(data_a),
    .flag(overrange_flag_a), .word(cap_w), .cnt(cap_n));

  always #4 clk = ~clk;

  // ****************************************************************
  // Expectations and helpers
  // ****************************************************************
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [14:0] code(input logic signed [15:0] s, input logic [1:0] f);
    logic signed [15:0] c;
    logic [13:0] o;
    c = s > 16'sh1fff ? 16'sh1fff : s < 16'she000 ? 16'she000 : s;
    o = c[13:0] ^ 14'h2000;
    return {c != s, f == 2'h1 ? c[13:0] : f == 2'h2 ? o ^ (o >> 1) : o};
  endfunction

  // Raw clock level wanders at random so the bypass path sees real traffic
  always @(posedge clk)
  begin
    d = nxt();
    raw_clk_duty <= d[0];
  end

  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task hang();
    error_cnt++;
    $display("[FAIL] %0t wait timed out", $time);
    results();
  endtask

  // ****************************************************************
  // Register bus
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++)
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    if (n == 50) hang();
    chk(s_axi_bresp, er, "bresp");
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++)
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    if (n == 50) hang();
    chk(s_axi_rdata & m, e, "rdata");
    chk(s_axi_rresp, er, "rresp");
    s_axi_rready <= 1'b0;
  endtask

  task automatic cod(input logic [15:0] x, input logic [1:0] f);
    @(posedge clk);
    sample_a <= x;
    sample_b <= -x;
    tk(20);
    chk({overrange_flag_a, data_a}, code(x, f), "code a");
    chk({overrange_flag_b, data_b}, code(-x, f), "code b");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    tk(16);
    rst <= 1'b0;
    rd(`REG_CONFIG, 32'hff, 32'h04, `RESP_OKAY);
    rd(`REG_POWER, 32'hff, 32'h0, `RESP_OKAY);
    rd(`REG_DIVIDE, 32'hff, 32'h0, `RESP_OKAY);
    rd(`REG_OUTPUT, 32'hff, 32'h0, `RESP_OKAY);
    rd(`REG_IRQ_MASK, 32'hff, 32'h0, `RESP_OKAY);
    rd(8'h20, 32'hffffffff, 32'h0, `RESP_SLVERR);
    wr(`REG_STATUS, 32'h0, `RESP_SLVERR);
    $display("test regs done");
    tk(2);
    cod(16'h0, 2'h0);
    @(posedge clk);
    sample_a <= 16'h0100;
    tk(12);
    #1 chk(data_a, 14'h2000, "lat old");
    tk(1);
    #1 chk(data_a, 14'h2100, "lat new");
    for (int f = 0; f < 4; f++)
    begin
      wr(`REG_CONFIG, 32'h4 | 32'(f), `RESP_OKAY);
      for (int i = 0; i < 7; i++)
      begin
        r = nxt();
        v = i < 5 ? cn[i] : {{2{r[13]}}, r[13:0]};
        cod(v, 2'(f));
      end
    end
    $display("test coding done");
    wr(`REG_CONFIG, 32'h4, `RESP_OKAY);
    wr(`REG_IRQ_MASK, 32'h1, `RESP_OKAY);
    cod(16'h2328, 2'h0);
    chk(irq, 1'b1, "irq up");
    cod(16'h0, 2'h0);
    chk(irq, 1'b1, "irq sticky");
    rd(`REG_IRQ_STATUS, 32'h3, 32'h3, `RESP_OKAY);
    tk(3);
    chk(irq, 1'b0, "irq clr");
    wr(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
    cod(16'hdcd8, 2'h0);
    chk(irq, 1'b0, "irq mask");
    rd(`REG_IRQ_STATUS, 32'h3, 32'h3, `RESP_OKAY);
    $display("test irq done");
    wr(`REG_OUTPUT, 32'h1, `RESP_OKAY);
    tk(2);
    chk({data_oe_a, data_oe_b}, 2'h1, "oe a");
    wr(`REG_OUTPUT, 32'h2, `RESP_OKAY);
    tk(2);
    chk({data_oe_a, data_oe_b}, 2'h2, "oe b");
    wr(`REG_OUTPUT, 32'h0, `RESP_OKAY);
    monitor_out_or_output_disable_pin <= 1'b1;
    tk(5);
    chk({data_oe_a, data_oe_b}, 2'h0, "oe pin");
    monitor_out_or_output_disable_pin <= 1'b0;
    tk(5);
    chk({data_oe_a, data_oe_b}, 2'h3, "oe back");
    power_down_ctl_pin <= 1'b1;
    tk(5);
    chk({data_clock_out_oe, data_oe_a, data_oe_b}, 3'h0, "pd pin");
    rd(`REG_STATUS, 32'h4, 32'h4, `RESP_OKAY);
    power_down_ctl_pin <= 1'b0;
    tk(5);
    chk({data_clock_out_oe, data_oe_a, data_oe_b}, 3'h7, "pd off");
    wr(`REG_POWER, 32'h1, `RESP_OKAY);
    tk(3);
    chk({data_clock_out_oe, data_oe_a, data_oe_b}, 3'h0, "pd reg");
    wr(`REG_POWER, 32'h2, `RESP_OKAY);
    rd(`REG_STATUS, 32'h14, 32'h10, `RESP_OKAY);
    wr(`REG_POWER, 32'h0, `RESP_OKAY);
    $display("test power done");
    cod(16'h0, 2'h0);
    chk({data_clock_out_a, data_clock_out_b}, 2'h3, "clk out");
    wr(`REG_CONFIG, 32'hc, `RESP_OKAY);
    tk(3);
    chk({data_clock_out_a, data_clock_out_b}, 2'h0, "clk out inv");
    wr(`REG_CONFIG, 32'h0, `RESP_OKAY);
    tk(300);
    rd(`REG_STATUS, 32'h3, 32'h2, `RESP_OKAY);
    wr(`REG_DIVIDE, 32'h1, `RESP_OKAY);
    tk(300);
    rd(`REG_STATUS, 32'h3, 32'h1, `RESP_OKAY);
    rd(`REG_IRQ_STATUS, 32'hc, 32'hc, `RESP_OKAY);
    hi = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1 hi += int'(internal_clk);
    end
    chk(hi, 32'd20, "duty");
    @(posedge clk);
    sample_a <= 16'h04d2;
    tk(40);
    chk(cap_w, code(16'h04d2, 2'h0), "cap");
    chk(cap_n > 0, 1'b1, "cap n");
    wr(`REG_DIVIDE, 32'h6, `RESP_OKAY);
    tk(300);
    rd(`REG_STATUS, 32'h1, 32'h0, `RESP_OKAY);
    $display("test clock done");
    rst <= 1'b1;
    serial_mode_pin <= 1'b0;
    serial_clock_or_format_select_pin <= 1'b1;
    serial_io_or_stabilizer_select_pin <= 1'b0;
    tk(16);
    rst <= 1'b0;
    cod(16'hfffb, 2'h1);
    tk(300);
    rd(`REG_STATUS, 32'h9, 32'h0, `RESP_OKAY);
    serial_io_or_stabilizer_select_pin <= 1'b1;
    serial_clock_or_format_select_pin <= 1'b0;
    tk(300);
    rd(`REG_STATUS, 32'h1, 32'h1, `RESP_OKAY);
    cod(16'hfffb, 2'h0);
    $display("test pins done");
    results();
  end
endmodule // adc_output_control_test
